// >>> pkg/level_status_pkg.sv
// Package for the per-level fetch address and level status logic.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package level_status_pkg;
    localparam int unsigned WORD_W     = 16;
    localparam int unsigned LEVEL_N    = 4;
    localparam int unsigned LEVEL_W    = 2;

    // Level status word bit positions
    localparam int unsigned BIT_EVEN   = 0;
    localparam int unsigned BIT_CARRY  = 1;
    localparam int unsigned BIT_OVFL   = 2;
    localparam int unsigned BIT_NEG    = 3;
    localparam int unsigned BIT_ZERO   = 4;
    localparam int unsigned BIT_SUPER  = 8;
    localparam int unsigned BIT_INPROC = 9;
    localparam int unsigned BIT_TRACE  = 10;
    localparam int unsigned BIT_SMASK  = 11;
    localparam logic [15:0] STATUS_USED_MASK = 16'h0F1F;
    localparam logic [15:0] STATUS_RESET     = 16'h0000;
    localparam logic [15:0] FETCH_RESET      = 16'h0000;
    localparam logic [15:0] FETCH_STEP       = 16'h0002;

    // Register map: fetch address of level n at FETCH_BASE + 4n,
    // status word of level n at STATUS_BASE + 4n, live state at LIVE_OFS.
    localparam logic [7:0] FETCH_BASE  = 8'h00;
    localparam logic [7:0] STATUS_BASE = 8'h10;
    localparam logic [7:0] CTRL_OFS    = 8'h20;
    localparam logic [7:0] LIVE_OFS    = 8'h24;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    typedef enum logic [3:0] {
        OP_NONE    = 4'h0,
        OP_ADD     = 4'h1,
        OP_SUB     = 4'h2,
        OP_COMPARE = 4'h3,
        OP_LOGIC   = 4'h4,
        OP_MUL     = 4'h5,
        OP_DIV     = 4'h6,
        OP_COMPL   = 4'h7,
        OP_SHIFTL  = 4'h8,
        OP_SETIND  = 4'h9,
        OP_LOADLB  = 4'hA,
        OP_IOCOND  = 4'hB,
        OP_LEXIT   = 4'hC
    } op_e;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } bus_state_e;

    typedef struct packed {
        logic        valid;
        logic [1:0]  level;
        op_e         op;
        logic [4:0]  upd_mask;
        logic [15:0] opa;
        logic [15:0] opb;
        logic [4:0]  shift_count;
        logic [15:0] load_data;
        logic [2:0]  io_code;
    } exec_req_s;

    typedef struct packed {
        logic        even;
        logic        carry;
        logic        ovfl;
        logic        neg;
        logic        zero;
    } flags_s;
endpackage

// >>> design/level_status_flags.sv
// Per-level fetch address and status word logic with indicator generation.
// Assumes the sequencer presents one fetch or execute event per cycle at most
// per port, and branch logic samples the status outputs combinatorially.
//
// Notes on behaviour
// - Each fetch address is 16 bits and advances right after every fetch.
// - One fetch address register per priority level, indexed by level.
// - Status word is 16 bits; seven unused bits always read zero.
// - Condition indicators sit in status word bits zero to four.
// - Each instruction selects none, all or a subset of indicators to update.
// - Even, negative, zero follow latest arithmetic, logical or move result.
// - Positive result means zero and negative indicators both clear.
// - Multiply and divide are signed; divide by zero sets carry.
// - Multiply product not fitting the destination sets overflow.
// - After I/O operate or I/O interrupt, even/carry/overflow hold condition code.
// - Complementing the most negative value sets overflow.
// - Set-flags and load-level-block load every indicator from supplied data.
// - One add/subtract path serves signed and unsigned alike.
// - Add/subtract carry marks unsigned overflow.
// - Add/subtract overflow marks signed overflow.
// - Left shift carry is the last bit shifted out.
// - Left shift overflow set if the top bit changed during the shift.
// - Compare subtracts first from second, flags as subtract, operands kept.
// - Branch taken when named condition holds, else next instruction.
// - Bit eight is supervisor state when one, problem state when zero.
// - Bit nine marks level active or preempted; level exit clears it.
// - Bit ten set raises a trace request at each instruction start.
// - Bit eleven clear inhibits all priority interrupts.
//
// Added by the designer: register access over Wishbone and the placing of the registers.
module level_status_flags #(
    parameter int unsigned LEVELS = level_status_pkg::LEVEL_N
) (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    // Wishbone slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [7:0]                  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    // Sequencer side
    input  wire logic                        fetch_done,
    input  wire logic [1:0]                  fetch_level,
    input  wire logic                        instr_start,
    input  wire level_status_pkg::exec_req_s exec_req,
    output logic      [15:0]                 result,
    // Branch logic side
    input  wire logic [3:0]                  branch_cond,
    input  wire logic                        branch_invert,
    output logic                             branch_taken,
    output logic      [15:0]                 status_word,
    output logic      [15:0]                 fetch_address,
    output logic                             trace_request,
    output logic                             interrupts_enabled,
    output logic                             supervisor_state
);

    logic [15:0]                  fetch_addr [LEVELS];
    logic [15:0]                  status     [LEVELS];
    logic [1:0]                   active_level;
    level_status_pkg::bus_state_e bus_state;
    level_status_pkg::flags_s     calc;
    logic [15:0]                  calc_result;
    logic                         wb_req;
    logic [7:0]                   reg_ofs;
    logic [1:0]                   reg_idx;
    logic [31:0]                  read_mux;
    logic                         wb_wr;

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
        logic [15:0] m;
        m = old_v;
        if (sel[0]) begin
            m[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            m[15:8] = new_v[15:8];
        end
        return m;
    endfunction

    // Result flags shared by every operation that sets them
    function automatic logic [2:0] result_flags(input logic [15:0] r);
        return {~r[0], r[15], r == 16'h0000};
    endfunction

    assign wb_req  = wb_cyc_i && wb_stb_i && bus_state == level_status_pkg::BUS_IDLE;
    assign reg_ofs = {wb_adr_i[7:2], 2'b00};
    assign reg_idx = wb_adr_i[3:2];
    // Writes land on the edge where the master sees ack high
    assign wb_wr   = wb_cyc_i && wb_stb_i && wb_we_i
                     && bus_state == level_status_pkg::BUS_ACK;

    // Indicator and result generation
    always_comb begin
        logic [16:0] sum;
        logic [31:0] prod;
        logic [15:0] sh;
        logic [15:0] a;
        logic [15:0] b;
        logic        top_changed;
        logic        last_out;
        logic [2:0]  rf;
        sum         = 17'h00000;
        prod        = 32'h0000_0000;
        sh          = 16'h0000;
        top_changed = 1'b0;
        last_out    = 1'b0;
        rf          = 3'h0;
        a           = exec_req.opa;
        b           = exec_req.opb;
        calc        = '0;
        calc_result = 16'h0000;
        case (exec_req.op)
            level_status_pkg::OP_ADD: begin
                sum         = {1'b0, a} + {1'b0, b};
                calc_result = sum[15:0];
                calc.carry  = sum[16];
                calc.ovfl   = (a[15] == b[15]) && (sum[15] != a[15]);
            end
            level_status_pkg::OP_SUB, level_status_pkg::OP_COMPARE: begin
                // b minus a: first operand subtracted from the second
                sum         = {1'b0, b} + {1'b0, ~a} + 17'h00001;
                calc_result = sum[15:0];
                calc.carry  = ~sum[16];
                calc.ovfl   = (a[15] != b[15]) && (sum[15] != b[15]);
            end
            level_status_pkg::OP_LOGIC: begin
                calc_result = b;
            end
            level_status_pkg::OP_MUL: begin
                prod        = 32'($signed(a) * $signed(b));
                calc_result = prod[15:0];
                calc.ovfl   = prod[31:15] != {17{prod[15]}};
            end
            level_status_pkg::OP_DIV: begin
                if (a == 16'h0000) begin
                    calc.carry  = 1'b1;
                    calc_result = b;
                end else begin
                    calc_result = 16'($signed(b) / $signed(a));
                    calc.ovfl   = (b == 16'h8000) && (a == 16'hFFFF);
                end
            end
            level_status_pkg::OP_COMPL: begin
                calc_result = 16'(~a + 16'h0001);
                calc.ovfl   = a == 16'h8000;
            end
            level_status_pkg::OP_SHIFTL: begin
                sh = a;
                for (int i = 0; i < 16; i++) begin
                    if (i < int'(exec_req.shift_count)) begin
                        last_out = sh[15];
                        sh       = {sh[14:0], 1'b0};
                        if (sh[15] != a[15]) begin
                            top_changed = 1'b1;
                        end
                    end
                end
                calc_result = sh;
                calc.carry  = last_out;
                calc.ovfl   = top_changed;
            end
            default: begin
                calc_result = 16'h0000;
            end
        endcase
        rf        = result_flags(calc_result);
        calc.even = rf[2];
        calc.neg  = rf[1];
        calc.zero = rf[0];
    end

    // Active level follows the most recent fetch
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            active_level <= 2'b00;
        end else if (fetch_done) begin
            active_level <= fetch_level;
        end
    end

    // Fetch address per level, advanced after every fetch
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < LEVELS; i++) begin
                fetch_addr[i] <= level_status_pkg::FETCH_RESET;
            end
        end else begin
            if (wb_wr && reg_ofs[7:4] == level_status_pkg::FETCH_BASE[7:4]) begin
                fetch_addr[reg_idx] <= merge16(fetch_addr[reg_idx], wb_dat_i, wb_sel_i);
            end
            if (fetch_done) begin
                fetch_addr[fetch_level] <= fetch_addr[fetch_level] + level_status_pkg::FETCH_STEP;
            end
        end
    end

    // Status word per level; execution wins over a bus write in the same cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < LEVELS; i++) begin
                status[i] <= level_status_pkg::STATUS_RESET;
            end
        end else begin
            if (wb_wr && reg_ofs[7:4] == level_status_pkg::STATUS_BASE[7:4]) begin
                status[reg_idx] <= merge16(status[reg_idx], wb_dat_i, wb_sel_i)
                                   & level_status_pkg::STATUS_USED_MASK;
            end
            if (exec_req.valid) begin
                case (exec_req.op)
                    level_status_pkg::OP_NONE: begin
                        status[exec_req.level] <= status[exec_req.level];
                    end
                    level_status_pkg::OP_SETIND: begin
                        status[exec_req.level][4:0] <= exec_req.load_data[4:0];
                    end
                    level_status_pkg::OP_LOADLB: begin
                        status[exec_req.level] <= exec_req.load_data
                                                  & level_status_pkg::STATUS_USED_MASK;
                    end
                    level_status_pkg::OP_IOCOND: begin
                        // Code bit 2 lands in even, bit 0 in overflow
                        status[exec_req.level][level_status_pkg::BIT_EVEN]  <= exec_req.io_code[2];
                        status[exec_req.level][level_status_pkg::BIT_CARRY] <= exec_req.io_code[1];
                        status[exec_req.level][level_status_pkg::BIT_OVFL]  <= exec_req.io_code[0];
                    end
                    level_status_pkg::OP_LEXIT: begin
                        status[exec_req.level][level_status_pkg::BIT_INPROC] <= 1'b0;
                    end
                    default: begin
                        // Per-instruction subset of indicators
                        for (int k = 0; k < 5; k++) begin
                            if (exec_req.upd_mask[k]) begin
                                status[exec_req.level][k] <= calc_vec(calc, k);
                            end
                        end
                    end
                endcase
            end
        end
    end

    function automatic logic calc_vec(input level_status_pkg::flags_s f, input int k);
        logic [4:0] v;
        v = {f.zero, f.neg, f.ovfl, f.carry, f.even};
        return v[k[2:0]];
    endfunction

    // Branch decision on the active level's indicators
    always_ff @(posedge clk_sys) begin
        logic [15:0] s;
        logic        c;
        s = status[active_level];
        case (branch_cond)
            4'h0:    c = s[4];
            4'h1:    c = ~s[4] & ~s[3];
            4'h2:    c = s[3];
            4'h3:    c = s[0];
            4'h4:    c = s[3] ^ s[2];
            4'h5:    c = (s[3] ^ s[2]) | s[4];
            4'h6:    c = s[1];
            4'h7:    c = s[1] | s[4];
            default: c = 1'b0;
        endcase
        if (reset) begin
            branch_taken <= 1'b0;
        end else begin
            branch_taken <= c ^ branch_invert;
        end
    end

    // Outputs from flip-flops; compare keeps operands by returning none
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            result             <= 16'h0000;
            status_word        <= level_status_pkg::STATUS_RESET;
            fetch_address      <= level_status_pkg::FETCH_RESET;
            trace_request      <= 1'b0;
            interrupts_enabled <= 1'b0;
            supervisor_state   <= 1'b0;
        end else begin
            if (exec_req.valid && exec_req.op != level_status_pkg::OP_COMPARE) begin
                result <= calc_result;
            end
            status_word        <= status[active_level];
            fetch_address      <= fetch_addr[active_level];
            trace_request      <= instr_start
                                  && status[active_level][level_status_pkg::BIT_TRACE];
            interrupts_enabled <= status[active_level][level_status_pkg::BIT_SMASK];
            supervisor_state   <= status[active_level][level_status_pkg::BIT_SUPER];
        end
    end

    // Wishbone read mux and single-cycle acknowledge
    always_comb begin
        read_mux = level_status_pkg::UNMAPPED_READ;
        if (reg_ofs[7:4] == level_status_pkg::FETCH_BASE[7:4]) begin
            read_mux = {16'h0000, fetch_addr[reg_idx]};
        end else if (reg_ofs[7:4] == level_status_pkg::STATUS_BASE[7:4]) begin
            read_mux = {16'h0000, status[reg_idx] & level_status_pkg::STATUS_USED_MASK};
        end else if (reg_ofs == level_status_pkg::LIVE_OFS) begin
            read_mux = {14'h0000, active_level, status[active_level]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bus_state <= level_status_pkg::BUS_IDLE;
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= 32'h0000_0000;
        end else begin
            case (bus_state)
                level_status_pkg::BUS_IDLE: begin
                    wb_ack_o <= wb_req;
                    if (wb_req) begin
                        wb_dat_o  <= wb_we_i ? 32'h0000_0000 : read_mux;
                        bus_state <= level_status_pkg::BUS_ACK;
                    end
                end
                level_status_pkg::BUS_ACK: begin
                    wb_ack_o  <= 1'b0;
                    bus_state <= level_status_pkg::BUS_IDLE;
                end
                default: begin
                    wb_ack_o  <= 1'b0;
                    bus_state <= level_status_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    a_sub_carry: assert property (@(posedge clk_sys) disable iff (reset)
        exec_req.valid && exec_req.op == level_status_pkg::OP_SUB && exec_req.upd_mask[1]
        && exec_req.opa > exec_req.opb |=> status[$past(exec_req.level)][1])
        else $error("subtract borrow did not set carry");
    a_compl_ovfl: assert property (@(posedge clk_sys) disable iff (reset)
        exec_req.valid && exec_req.op == level_status_pkg::OP_COMPL && exec_req.upd_mask[2]
        && exec_req.opa == 16'h8000 |=> status[$past(exec_req.level)][2])
        else $error("complement of most negative did not set overflow");
    a_div_zero: assert property (@(posedge clk_sys) disable iff (reset)
        exec_req.valid && exec_req.op == level_status_pkg::OP_DIV && exec_req.upd_mask[1]
        && exec_req.opa == 16'h0000 |=> status[$past(exec_req.level)][1])
        else $error("divide by zero did not set carry");

    a_unused_zero: assert property (@(posedge clk_sys) disable iff (reset)
        (status_word & ~level_status_pkg::STATUS_USED_MASK) == 16'h0000)
        else $error("unused status bits not zero");
    a_fetch_step: assert property (@(posedge clk_sys) disable iff (reset)
        fetch_done && !wb_wr |=> fetch_addr[$past(fetch_level)]
        == $past(fetch_addr[fetch_level]) + level_status_pkg::FETCH_STEP)
        else $error("fetch address did not advance");
    a_lexit_clear: assert property (@(posedge clk_sys) disable iff (reset)
        exec_req.valid && exec_req.op == level_status_pkg::OP_LEXIT
        |=> !status[$past(exec_req.level)][9])
        else $error("level exit left in-process set");
    a_zero_flag: assert property (@(posedge clk_sys) disable iff (reset)
        exec_req.valid && exec_req.op == level_status_pkg::OP_ADD && exec_req.upd_mask[4]
        && 16'(exec_req.opa + exec_req.opb) == 16'h0000 |=> status[$past(exec_req.level)][4])
        else $error("zero result did not set zero");

    a_bus_ack: assert property (@(posedge clk_sys) disable iff (reset)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held beyond one cycle");
endmodule

// >>> test/seq_model.sv
// Sequencer model: drives fetch, instruction start and execute pulses.
// Assumes the block samples these on the rising edge of the shared clock.
module seq_model (
    // Clock
    input  wire logic                   clk_sys,
    // Toward the block
    output logic                        fetch_done,
    output logic [1:0]                  fetch_level,
    output logic                        instr_start,
    output level_status_pkg::exec_req_s exec_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        fetch_done = 1'b0;
        fetch_level = 2'h0;
        instr_start = 1'b0;
        exec_req = '0;
    end
    // Released level lines show the inverse so a stale value is never trusted
    task automatic fetch(input logic [1:0] lv);
        fetch_done <= 1'b1;
        fetch_level <= lv;
        @(posedge clk_sys);
        fetch_done <= 1'b0;
        fetch_level <= ~lv;
        @(posedge clk_sys);
    endtask
    task automatic start();
        instr_start <= 1'b1;
        @(posedge clk_sys);
        instr_start <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic exec(input logic [1:0] lv, input level_status_pkg::op_e op,
                        input logic [4:0] mk, input logic [15:0] a, input logic [15:0] b,
                        input logic [4:0] sh, input logic [15:0] ld, input logic [2:0] io);
        level_status_pkg::exec_req_s x;
        x = '{1'b1, lv, op, mk, a, b, sh, ld, io};
        exec_req <= x;
        @(posedge clk_sys);
        x = level_status_pkg::exec_req_s'(~x);
        x.valid = 1'b0;
        exec_req <= x;
        @(posedge clk_sys);
    endtask
endmodule

// >>> test/test_level_status_flag_logic.sv
// Self-checking bench: integer model of fetch addresses and status flags.
// Assumes seq_model drives the sequencer side; the bench drives the bus.
module test_level_status_flag_logic;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys;
    logic        reset = 1'b1;
    logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'h0, branch_cond = 4'h0;
    logic [31:0] wb_dat = 32'h0, rdat, wb_q;
    logic        wb_ack, branch_invert = 1'b0, branch_taken, trace_request, ints_on, superv;
    logic        fetch_done, instr_start;
    logic [1:0]  fetch_level;
    logic [15:0] result, status_word, fetch_address;
    level_status_pkg::exec_req_s exec_req;
    int          err_count, comparisons, st[4], fa[4];
    level_status_flags DUT (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(rdat), .wb_ack_o(wb_ack), .fetch_done(fetch_done),
        .fetch_level(fetch_level), .instr_start(instr_start), .exec_req(exec_req),
        .result(result), .branch_cond(branch_cond), .branch_invert(branch_invert),
        .branch_taken(branch_taken), .status_word(status_word),
        .fetch_address(fetch_address), .trace_request(trace_request),
        .interrupts_enabled(ints_on), .supervisor_state(superv));
    seq_model u_seq (.clk_sys(clk_sys), .fetch_done(fetch_done), .fetch_level(fetch_level),
        .instr_start(instr_start), .exec_req(exec_req));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Reads the answer before this edge's updates land, as a real master would
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] d);
        int n;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= {2'b11, we, adr, sel, d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack !== 1'b1 && n < 64);
        wb_q = rdat;
        if (n >= 64) begin
            err_count++;
            print_verdict();
        end
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 4'h3, 32'h0);
        check("bus read", wb_q, exp);
    endtask
    function automatic int sx(int x);
        return (x > 32767) ? x - 65536 : x;
    endfunction
    function automatic int calc(int op, int a, int b, int sh, int ld, int io);
        int r, v;
        logic [4:0] f;
        f = 5'h0;
        r = (op == 1) ? a + b : (op == 4) ? b : b - a;
        case (op)
            1: f[2:1] = {a[15] == b[15] && r[15] != a[15], r[16]};
            2, 3: f[2:1] = {a[15] != b[15] && r[15] != b[15], r[16]};
            5: f[2] = sx(a) * sx(b) > 32767 || sx(a) * sx(b) < -32768;
            6: f[1] = (a == 0);
            7: f[2] = (a == 32'h8000);
            8: begin
                v = a;
                for (int k = 0; k < sh; k++) begin
                    f[1] = v[15];
                    v = v << 1;
                    if (v[15] != a[15]) f[2] = 1'b1;
                end
            end
            9, 10: f = 5'(ld);
            11: f[2:0] = {io[0], io[1], io[2]};
            default: f = 5'h0;
        endcase
        if (op < 5) f[4:3] = {r[15:0] == 16'h0, r[15]};
        if (op < 5) f[0] = !r[0];
        return int'(f);
    endfunction
    function automatic logic taken(int s, logic [3:0] c, logic inv);
        logic [4:0] v;
        logic t;
        v = 5'(s);
        case (c)
            0: t = v[4];
            1: t = !v[4] && !v[3];
            2: t = v[3];
            3: t = v[0];
            4: t = v[3] ^ v[2];
            5: t = (v[3] ^ v[2]) | v[4];
            6: t = v[1];
            default: t = v[1] | v[4];
        endcase
        return t ^ inv;
    endfunction
    initial begin
        int op, lv, a, b, mk, r, res, n;
        int masks[12] = '{0, 31, 31, 31, 25, 4, 2, 4, 6, 31, 31, 7};
        res = -1;
        void'($urandom(32'h60067DCE));
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            rd(8'(4 * i), 32'(level_status_pkg::FETCH_RESET));
            rd(8'h10 + 8'(4 * i), 32'(level_status_pkg::STATUS_RESET));
        end
        wb(1'b1, 8'h80, 4'h3, 32'hFFFFFFFF);
        rd(8'h80, level_status_pkg::UNMAPPED_READ);
        $display("test reset and map done");
        wb(1'b1, 8'h0C, 4'h3, 32'h0000FFFE);
        wb(1'b1, 8'h04, 4'h1, 32'h0000ABCD);
        fa[3] = 16'hFFFE;
        fa[1] = 16'h00CD;
        for (int i = 0; i < 13; i++) begin
            lv = (i == 12) ? 2 : $urandom_range(0, 3);
            u_seq.fetch(2'(lv));
            fa[lv] = (fa[lv] + int'(level_status_pkg::FETCH_STEP)) & 16'hFFFF;
        end
        repeat (2) @(posedge clk_sys);
        check("fetch_address", 32'(fetch_address), 32'(fa[2]));
        for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'(fa[i]));
        $display("test fetch address done");
        wb(1'b1, 8'h14, 4'h3, 32'hFFFFFFFF);
        rd(8'h14, 32'(level_status_pkg::STATUS_USED_MASK));
        st[1] = 16'h0F1F;
        wb(1'b1, 8'h1C, 4'h3, 32'h00000200);
        u_seq.exec(2'h3, level_status_pkg::OP_LEXIT, 5'h0, 16'h0, 16'h0, 5'h0, 16'h0, 3'h0);
        rd(8'h1C, 32'h0);
        wb(1'b1, 8'h18, 4'h3, 32'h00000D00);
        repeat (2) @(posedge clk_sys);
        check("supervisor_state", 32'(superv), 32'h1);
        check("interrupts_enabled", 32'(ints_on), 32'h1);
        check("status_word", 32'(status_word), 32'h0D00);
        rd(8'h24, 32'h20D00);
        u_seq.start();
        n = 0;
        while (trace_request !== 1'b1 && n < 4) begin
            @(posedge clk_sys);
            n++;
        end
        check("trace_request", 32'(trace_request), 32'h1);
        $display("test status modes done");
        for (int i = 0; i < 150; i++) begin
            op = $urandom_range(0, 11);
            lv = (i % 2) ? 2 : $urandom_range(0, 3);
            a = (i % 3) ? $urandom_range(0, 65535) : $urandom_range(0, 127);
            b = (i % 3) ? $urandom_range(0, 65535) : $urandom_range(0, 127);
            if (op == 7 && i % 4 == 0) a = 32'h8000;
            if (op == 6) a = (i % 4 < 2) ? 0 : a | 1;
            if (op == 6) b = (i % 4 < 2) ? 0 : b | 1;
            mk = (op > 8 || i % 3) ? masks[op] : masks[op] & $urandom_range(0, 31);
            st[lv] = (st[lv] & ~mk) | (calc(op, a, b, i % 15 + 1, $urandom_range(0, 31),
                     i % 8) & mk);
            u_seq.exec(2'(lv), level_status_pkg::op_e'(4'(op)), 5'(mk), 16'(a), 16'(b),
                       5'(i % 15 + 1), 16'(st[lv] & 31), 3'(i % 8));
            r = (op == 1) ? a + b : b - a;
            if (op < 3) res = op ? r & 16'hFFFF : -1;
            if (op < 4 && res >= 0) check("result", 32'(result), 32'(res));
            if (op > 3) res = -1;
            wb(1'b0, 8'h10 + 8'(4 * lv), 4'h3, 32'h0);
            check("flags", wb_q & 32'h1F, 32'(st[lv] & 31));
            if (lv == 2) begin
                branch_cond <= 4'($urandom_range(0, 7));
                branch_invert <= 1'($urandom_range(0, 1));
                repeat (3) @(posedge clk_sys);
                check("branch_taken", 32'(branch_taken),
                      32'(taken(st[2], branch_cond, branch_invert)));
            end
        end
        $display("test indicators done");
        print_verdict();
    end
endmodule
